// ===== logic/scs_sequencer.v
/*
 smart card interface sequencer top: activation gating, ordered deactivation,
 fault/presence status, chip select latching and three io line pairs.
 assumes all inputs synchronous to clk; analog supervisors report as levels.
*/
// How it works
// - card lines held low while deactivated
// - card lines low after request until ready
// - activate only when card present, status high
// - deactivate on release, fault, power-down acknowledge
// - over-current, under-voltage, withdrawal are faults
// - reset, then clock, then io drop in order
// - supply enable drops last after t4
// - host clock passed through unreshaped
// - in idle status shows card presence
// - fault pulls status low, starts deactivation
// - chip select high: live inputs, data passes
// - chip select low latches host inputs
// - chip select low blocks io/aux transfer
// - chip select low floats status and ready
// - fault sensing ignores chip select
// - after reset card lines low, host high
// - first falling edge line becomes input
// - input rising edge returns pair neutral
// - ready after supply good for 20 us
// - edge-triggered supply select, 400 ns pairing
// - ready check 510 us after request
`timescale 1ns/1ps
`include "scs_defines.vh"

module scs_sequencer #(
    parameter RDY_SETTLE_CYC = `SCS_RDY_SETTLE_CYC,
    parameter RDY_CHECK_CYC  = `SCS_RDY_CHECK_CYC
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       chip_select,
    input  wire       supply_request_mid_n,
    input  wire       supply_request_high_n,
    input  wire       host_card_reset_in,
    input  wire       host_card_clock_in,
    input  wire       card_presence_in,
    input  wire       power_down_ack,
    input  wire       card_overcurrent,
    input  wire       card_supply_good,
    input  wire       host_io_line_in,
    output wire       host_io_line_out,
    output wire       host_io_line_oe_n,
    input  wire       host_aux_line_a_in,
    output wire       host_aux_line_a_out,
    output wire       host_aux_line_a_oe_n,
    input  wire       host_aux_line_b_in,
    output wire       host_aux_line_b_out,
    output wire       host_aux_line_b_oe_n,
    input  wire       card_io_line_in,
    output wire       card_io_line_out,
    output wire       card_io_line_oe_n,
    input  wire       card_aux_line_a_in,
    output wire       card_aux_line_a_out,
    output wire       card_aux_line_a_oe_n,
    input  wire       card_aux_line_b_in,
    output wire       card_aux_line_b_out,
    output wire       card_aux_line_b_oe_n,
    output wire       host_pullup_strong,
    output reg        card_clock_out,
    output reg        card_reset_out,
    output reg        supply_enable,
    output reg  [1:0] supply_select,
    output wire       card_status_n_out,
    output wire       card_status_n_oe_n,
    output wire       ready_out,
    output wire       ready_oe_n,
    output wire       status_pullup_en
);

////////////////////////////////////////////////////////////////////////////////
// chip select latching

reg  lat_mid_n;
reg  lat_high_n;
reg  lat_rst;
reg  lat_clk;

always @(posedge clk) begin
    if (!rst_n) begin
        lat_mid_n  <= 1'b1;
        lat_high_n <= 1'b1;
        lat_rst    <= 1'b0;
        lat_clk    <= 1'b0;
    end else if (chip_select) begin
        lat_mid_n  <= supply_request_mid_n;
        lat_high_n <= supply_request_high_n;
        lat_rst    <= host_card_reset_in;
        lat_clk    <= host_card_clock_in;
    end
end

// live while selected, held while deselected
wire eff_mid_n  = chip_select ? supply_request_mid_n  : lat_mid_n;
wire eff_high_n = chip_select ? supply_request_high_n : lat_high_n;
wire eff_rst    = chip_select ? host_card_reset_in    : lat_rst;
wire eff_clk    = chip_select ? host_card_clock_in    : lat_clk;

////////////////////////////////////////////////////////////////////////////////
// supply request edge detection and pairing

reg        prev_mid_n;
reg        prev_high_n;
reg  [2:0] pair_cnt;
wire       fall_mid  = prev_mid_n  && !eff_mid_n;
wire       fall_high = prev_high_n && !eff_high_n;
wire       both_high = eff_mid_n && eff_high_n;

always @(posedge clk) begin
    if (!rst_n) begin
        prev_mid_n  <= 1'b1;
        prev_high_n <= 1'b1;
    end else begin
        prev_mid_n  <= eff_mid_n;
        prev_high_n <= eff_high_n;
    end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer

reg  [2:0]             state;
reg  [2:0]             next_state;
reg  [`SCS_TMR_W-1:0]  step_cnt;
reg  [`SCS_TMR_W-1:0]  settle_cnt;
reg                    ready;
reg                    status_n;
reg                    check_done;

localparam integer T1_LOAD  = `SCS_T1_CYC - 1;
localparam integer T2_LOAD  = `SCS_T2_CYC - 1;
localparam integer T3_LOAD  = `SCS_T3_CYC - 1;
localparam integer T4_LOAD  = `SCS_T4_CYC - 1;
localparam integer PAIR_WIN = `SCS_PAIR_WIN_CYC;

wire in_session = (state == `SCS_ST_WAIT_RDY) || (state == `SCS_ST_ACTIVE);
wire hw_fault   = card_overcurrent || !card_presence_in ||
                  (ready && !card_supply_good);
wire rdy_late   = (state == `SCS_ST_WAIT_RDY) && !check_done &&
                  (step_cnt == RDY_CHECK_CYC[`SCS_TMR_W-1:0] - 1'b1) && !ready;
wire abort      = in_session && (both_high || hw_fault || power_down_ack || rdy_late);
wire step_done  = (step_cnt == {`SCS_TMR_W{1'b0}});

always @* begin
    next_state = state;
    case (state)
        `SCS_ST_IDLE: begin
            if ((fall_mid || fall_high) && card_presence_in && status_n && !power_down_ack)
                next_state = `SCS_ST_WAIT_RDY;
        end
        `SCS_ST_WAIT_RDY: begin
            if (abort)
                next_state = `SCS_ST_DEACT_RST;
            else if (ready)
                next_state = `SCS_ST_ACTIVE;
        end
        `SCS_ST_ACTIVE: begin
            if (abort)
                next_state = `SCS_ST_DEACT_RST;
        end
        `SCS_ST_DEACT_RST: if (step_done) next_state = `SCS_ST_DEACT_CLK;
        `SCS_ST_DEACT_CLK: if (step_done) next_state = `SCS_ST_DEACT_IO;
        `SCS_ST_DEACT_IO:  if (step_done) next_state = `SCS_ST_DEACT_VCC;
        `SCS_ST_DEACT_VCC: if (step_done) next_state = `SCS_ST_IDLE;
        default: next_state = `SCS_ST_IDLE;
    endcase
end

always @(posedge clk) begin
    if (!rst_n) begin
        state         <= `SCS_ST_IDLE;
        step_cnt      <= {`SCS_TMR_W{1'b0}};
        check_done    <= 1'b0;
        supply_enable <= 1'b0;
        supply_select <= `SCS_VSEL_NONE;
        pair_cnt      <= 3'h0;
    end else begin
        state <= next_state;
        case (next_state)
            `SCS_ST_DEACT_RST: step_cnt <= (state != `SCS_ST_DEACT_RST) ?
                                           T1_LOAD[`SCS_TMR_W-1:0] : step_cnt - 1'b1;
            `SCS_ST_DEACT_CLK: step_cnt <= (state != `SCS_ST_DEACT_CLK) ?
                                           T2_LOAD[`SCS_TMR_W-1:0] : step_cnt - 1'b1;
            `SCS_ST_DEACT_IO:  step_cnt <= (state != `SCS_ST_DEACT_IO) ?
                                           T3_LOAD[`SCS_TMR_W-1:0] : step_cnt - 1'b1;
            `SCS_ST_DEACT_VCC: step_cnt <= (state != `SCS_ST_DEACT_VCC) ?
                                           T4_LOAD[`SCS_TMR_W-1:0] : step_cnt - 1'b1;
            `SCS_ST_WAIT_RDY:  step_cnt <= (state != `SCS_ST_WAIT_RDY) ?
                                           {`SCS_TMR_W{1'b0}} : step_cnt + 1'b1;
            default:           step_cnt <= {`SCS_TMR_W{1'b0}};
        endcase
        if (state == `SCS_ST_IDLE)
            check_done <= 1'b0;
        else if (state == `SCS_ST_WAIT_RDY && step_cnt == RDY_CHECK_CYC[`SCS_TMR_W-1:0] - 1'b1)
            check_done <= 1'b1;
        // supply voltage choice, edge triggered with pairing window
        if (state == `SCS_ST_IDLE && next_state == `SCS_ST_WAIT_RDY) begin
            supply_enable <= 1'b1;
            pair_cnt      <= PAIR_WIN[2:0];
            if (fall_mid && fall_high)
                supply_select <= `SCS_VSEL_LOW;
            else if (fall_mid)
                supply_select <= `SCS_VSEL_MID;
            else
                supply_select <= `SCS_VSEL_HIGH;
        end else if (pair_cnt != 3'h0) begin
            pair_cnt <= pair_cnt - 3'h1;
            if ((supply_select == `SCS_VSEL_MID && fall_high) ||
                (supply_select == `SCS_VSEL_HIGH && fall_mid))
                supply_select <= `SCS_VSEL_LOW;
        end
        if (state == `SCS_ST_DEACT_VCC && step_done) begin
            supply_enable <= 1'b0;
            supply_select <= `SCS_VSEL_NONE;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// ready indication and status output

always @(posedge clk) begin
    if (!rst_n) begin
        settle_cnt <= {`SCS_TMR_W{1'b0}};
        ready      <= 1'b0;
        status_n   <= 1'b0;
    end else begin
        if (!supply_enable || !card_supply_good || !in_session) begin
            settle_cnt <= {`SCS_TMR_W{1'b0}};
            ready      <= 1'b0;
        end else if (settle_cnt == RDY_SETTLE_CYC[`SCS_TMR_W-1:0] - 1'b1) begin
            ready      <= 1'b1;
        end else begin
            settle_cnt <= settle_cnt + 1'b1;
        end
        if (in_session && (hw_fault || rdy_late))
            status_n <= 1'b0;
        else if (state == `SCS_ST_IDLE)
            status_n <= card_presence_in;
    end
end

assign card_status_n_out  = status_n;
assign card_status_n_oe_n = !chip_select || status_n;
assign ready_out          = ready;
assign ready_oe_n         = !chip_select || ready;
assign status_pullup_en   = chip_select;
assign host_pullup_strong = chip_select;

////////////////////////////////////////////////////////////////////////////////
// card clock and reset forwarding

wire fwd_ok  = (state == `SCS_ST_ACTIVE) && ready;
wire rst_ok  = fwd_ok;
wire clk_ok  = fwd_ok || (state == `SCS_ST_DEACT_RST);

always @(posedge clk) begin
    if (!rst_n) begin
        card_clock_out <= 1'b0;
        card_reset_out <= 1'b0;
    end else begin
        card_reset_out <= rst_ok && eff_rst;
        card_clock_out <= clk_ok && eff_clk;
    end
end

////////////////////////////////////////////////////////////////////////////////
// io and aux line pairs

// reception stays on while deselected; inputs held idle so nothing passes
wire io_enable  = fwd_ok || (state == `SCS_ST_DEACT_RST) || (state == `SCS_ST_DEACT_CLK);
wire [2:0] h_in = chip_select ? {host_aux_line_b_in, host_aux_line_a_in, host_io_line_in} : 3'h7;
wire [2:0] c_in = chip_select ? {card_aux_line_b_in, card_aux_line_a_in, card_io_line_in} : 3'h7;
wire [2:0] h_out;
wire [2:0] h_oe_n;
wire [2:0] c_out;
wire [2:0] c_oe_n;

genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pair
        scs_io_pair u_pair (
            .clk       (clk),
            .rst_n     (rst_n),
            .enable    (io_enable),
            .host_in   (h_in[gi]),
            .host_out  (h_out[gi]),
            .host_oe_n (h_oe_n[gi]),
            .card_in   (c_in[gi]),
            .card_out  (c_out[gi]),
            .card_oe_n (c_oe_n[gi])
        );
    end
endgenerate

assign host_io_line_out     = h_out[0];
assign host_io_line_oe_n    = h_oe_n[0];
assign host_aux_line_a_out  = h_out[1];
assign host_aux_line_a_oe_n = h_oe_n[1];
assign host_aux_line_b_out  = h_out[2];
assign host_aux_line_b_oe_n = h_oe_n[2];
assign card_io_line_out     = c_out[0];
assign card_io_line_oe_n    = c_oe_n[0];
assign card_aux_line_a_out  = c_out[1];
assign card_aux_line_a_oe_n = c_oe_n[1];
assign card_aux_line_b_out  = c_out[2];
assign card_aux_line_b_oe_n = c_oe_n[2];

endmodule

// ===== logic/scs_defines.vh
/*
 smart card interface sequencer: constants, timing counts and state codes.
 assumes a 10 MHz clock (100 ns period).
*/
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH

`define SCS_CLK_PERIOD_NS   100
`define SCS_T1_NS           200
`define SCS_T2_NS           200
`define SCS_T3_NS           200
`define SCS_T4_NS           200
`define SCS_T1_CYC          ((`SCS_T1_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`define SCS_T2_CYC          ((`SCS_T2_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`define SCS_T3_CYC          ((`SCS_T3_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`define SCS_T4_CYC          ((`SCS_T4_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`define SCS_RDY_SETTLE_NS   20000
`define SCS_RDY_SETTLE_CYC  ((`SCS_RDY_SETTLE_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`define SCS_RDY_CHECK_NS    510000
`define SCS_RDY_CHECK_CYC   (`SCS_RDY_CHECK_NS / `SCS_CLK_PERIOD_NS)
`define SCS_PAIR_WIN_NS     400
`define SCS_PAIR_WIN_CYC    (`SCS_PAIR_WIN_NS / `SCS_CLK_PERIOD_NS)
`define SCS_TMR_W           13

`define SCS_ST_IDLE         3'h0
`define SCS_ST_WAIT_RDY     3'h1
`define SCS_ST_ACTIVE       3'h2
`define SCS_ST_DEACT_RST    3'h3
`define SCS_ST_DEACT_CLK    3'h4
`define SCS_ST_DEACT_IO     3'h5
`define SCS_ST_DEACT_VCC    3'h6

`define SCS_VSEL_NONE       2'h0
`define SCS_VSEL_MID        2'h1
`define SCS_VSEL_HIGH       2'h2
`define SCS_VSEL_LOW        2'h3

`define SCS_DIR_NEUTRAL     2'h0
`define SCS_DIR_A_IN        2'h1
`define SCS_DIR_B_IN        2'h2

`endif

// ===== logic/scs_io_pair.v
/*
 one bidirectional line pair with first-falling-edge direction resolution.
 assumes both line inputs are synchronous to clk; open-drain, oe low = drive.
*/
`timescale 1ns/1ps
`include "scs_defines.vh"

module scs_io_pair (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       enable,
    input  wire       host_in,
    output wire       host_out,
    output wire       host_oe_n,
    input  wire       card_in,
    output wire       card_out,
    output wire       card_oe_n
);

reg [1:0] dir;
reg       host_prev;
reg       card_prev;
reg       host_hold;
reg       card_hold;
reg [1:0] next_dir;

always @* begin
    next_dir = dir;
    if (!enable) begin
        next_dir = `SCS_DIR_NEUTRAL;
    end else begin
        case (dir)
            `SCS_DIR_NEUTRAL: begin
                if (host_prev && !host_in)
                    next_dir = `SCS_DIR_A_IN;
                else if (card_prev && !card_in)
                    next_dir = `SCS_DIR_B_IN;
            end
            `SCS_DIR_A_IN: begin
                if (!host_prev && host_in)
                    next_dir = `SCS_DIR_NEUTRAL;
            end
            `SCS_DIR_B_IN: begin
                if (!card_prev && card_in)
                    next_dir = `SCS_DIR_NEUTRAL;
            end
            default: next_dir = `SCS_DIR_NEUTRAL;
        endcase
    end
end

always @(posedge clk) begin
    if (!rst_n) begin
        dir       <= `SCS_DIR_NEUTRAL;
        host_prev <= 1'b1;
        card_prev <= 1'b0;
        host_hold <= 1'b1;
        card_hold <= 1'b0;
    end else begin
        dir       <= next_dir;
        host_prev <= host_in;
        card_prev <= card_in;
        host_hold <= (next_dir == `SCS_DIR_B_IN) ? card_in : 1'b1;
        card_hold <= !enable ? 1'b0 : ((next_dir == `SCS_DIR_A_IN) ? host_in : 1'b1);
    end
end

// host side releases to its pull-up unless it follows the card
assign host_out  = host_hold;
assign host_oe_n = !(dir == `SCS_DIR_B_IN && !host_hold);
// card side driven low when disabled, else follows host
assign card_out  = card_hold;
assign card_oe_n = enable ? !(dir == `SCS_DIR_A_IN && !card_hold) : 1'b0;

endmodule

// ===== testbench/scs_checker_assertions.sv
/*
 port checker for scs_sequencer: sequencing, fault, chip select relations.
 assumes binding into scs_sequencer and a card supply that settles in a cycle.
*/
`timescale 1ns/1ps

module scs_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       chip_select,
    input wire logic       supply_request_mid_n,
    input wire logic       supply_request_high_n,
    input wire logic       card_presence_in,
    input wire logic       power_down_ack,
    input wire logic       card_overcurrent,
    input wire logic       card_io_line_out,
    input wire logic       card_io_line_oe_n,
    input wire logic       card_aux_line_a_out,
    input wire logic       card_aux_line_b_out,
    input wire logic       host_pullup_strong,
    input wire logic       card_clock_out,
    input wire logic       card_reset_out,
    input wire logic       supply_enable,
    input wire logic [1:0] supply_select,
    input wire logic       card_status_n_out,
    input wire logic       card_status_n_oe_n,
    input wire logic       ready_out,
    input wire logic       ready_oe_n,
    input wire logic       status_pullup_en
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    a_idle_low: assert property (
        !supply_enable && !$past(supply_enable) |-> !card_clock_out && !card_reset_out && !card_io_line_out
        && !card_io_line_oe_n && !card_aux_line_a_out && !card_aux_line_b_out) else $error("card lines not low");
    a_hold_rdy: assert property (
        $rose(supply_enable) |-> (!card_clock_out && !card_reset_out) [*4]) else $error("card lines early");
    a_supply_on: assert property (
        chip_select && $fell(supply_request_mid_n) && supply_request_high_n && !supply_enable && card_presence_in
        && card_status_n_out && !power_down_ack |=> supply_enable && supply_select == 2'h1) else $error("no supply");
    a_no_card: assert property (
        !card_presence_in && !supply_enable |=> !supply_enable) else $error("activated without card");
    a_release_off: assert property (
        supply_enable && chip_select && supply_request_mid_n && supply_request_high_n |-> ##[1:16] !supply_enable)
        else $error("release did not deactivate");
    a_fault_flag: assert property (
        card_status_n_out && ready_out && $rose(card_overcurrent) |-> ##[1:2] !card_status_n_out)
        else $error("fault not flagged");
    a_fault_off: assert property (
        $fell(card_status_n_out) && supply_enable |-> ##[0:2] !card_reset_out ##[1:14] !supply_enable)
        else $error("fault did not deactivate");
    a_deact_order: assert property (
        $fell(supply_enable) |-> !card_reset_out && !card_clock_out && !card_io_line_out && !card_io_line_oe_n
        && $past(card_reset_out, 2) == 1'b0) else $error("supply dropped out of order");
    a_cs_float: assert property (
        !chip_select |-> card_status_n_oe_n && ready_oe_n && !status_pullup_en && !host_pullup_strong)
        else $error("outputs not released");
    c_ready: cover property ($rose(ready_out));
    c_fault: cover property ($fell(card_status_n_out) && supply_enable);
    c_latch: cover property (!chip_select && supply_enable);
endmodule

bind scs_sequencer scs_checker scs_checker_i (.*);

// ===== testbench/scs_card_model.sv
/*
 card side model: supply supervisor and the open-drain card io line.
 assumes the card line has a pull-up; sag holds the supply below threshold.
*/
`timescale 1ns/1ps

module scs_card_model (
    input  wire logic clk,
    input  wire logic supply_enable,
    input  wire logic sag,
    input  wire logic card_pull,
    input  wire logic io_out,
    input  wire logic io_oe_n,
    output logic      supply_good,
    output wire logic io_line
);
    initial supply_good = 1'b0;
    // supply reaches its level one cycle after enable
    always @(posedge clk) begin
        supply_good <= supply_enable && !sag;
    end
    // released line floats high, either party may pull it low
    assign io_line = (io_oe_n | io_out) & ~card_pull;
endmodule

// ===== testbench/scs_sequencer_tb.sv
/*
 self-checking bench for scs_sequencer: activation modes, deactivation causes,
 chip select latching, io direction. assumes short ready timing parameters.
*/
`timescale 1ns/1ps

module scs_sequencer_tb;
    logic clk = 1'b0, rst_n = 1'b0, chip_select = 1'b1, supply_request_mid_n = 1'b1, supply_request_high_n = 1'b1;
    logic host_card_reset_in = 1'b0, host_card_clock_in = 1'b0, card_presence_in = 1'b1, power_down_ack = 1'b0;
    logic card_overcurrent = 1'b0, sag = 1'b0, card_pull = 1'b0, host_pull = 1'b0;
    logic [31:0] seed = 32'h0001546b;
    int   err_count = 0, checks_done = 0, m;
    int   exp_sel[5] = '{1, 2, 3, 2, 1};
    wire  card_supply_good, host_io_line_in, host_aux_line_a_in, host_aux_line_b_in, card_io_line_in;
    wire  card_aux_line_a_in, card_aux_line_b_in, host_io_line_out, host_io_line_oe_n, host_aux_line_a_out;
    wire  host_aux_line_a_oe_n, host_aux_line_b_out, host_aux_line_b_oe_n, card_io_line_out, card_io_line_oe_n;
    wire  card_aux_line_a_out, card_aux_line_a_oe_n, card_aux_line_b_out, card_aux_line_b_oe_n, host_pullup_strong;
    wire  card_clock_out, card_reset_out, supply_enable, card_status_n_out, card_status_n_oe_n;
    wire  ready_out, ready_oe_n, status_pullup_en;
    wire  [1:0] supply_select;

    always #50 clk = ~clk;
    assign host_io_line_in = (host_io_line_oe_n | host_io_line_out) & ~host_pull;
    assign host_aux_line_a_in = host_aux_line_a_oe_n | host_aux_line_a_out;
    assign host_aux_line_b_in = host_aux_line_b_oe_n | host_aux_line_b_out;
    assign card_aux_line_a_in = card_aux_line_a_oe_n | card_aux_line_a_out;
    assign card_aux_line_b_in = card_aux_line_b_oe_n | card_aux_line_b_out;

    scs_sequencer #(.RDY_SETTLE_CYC(4), .RDY_CHECK_CYC(40)) scs_sequencer_i (.*);
    scs_card_model scs_card_model_i (.clk(clk), .supply_enable(supply_enable), .sag(sag), .card_pull(card_pull),
        .io_out(card_io_line_out), .io_oe_n(card_io_line_oe_n), .supply_good(card_supply_good),
        .io_line(card_io_line_in));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic end_sim;
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_on(input int which, input logic v, input int lim);
        int n;
        n = 0;
        while ((which ? ready_out : supply_enable) !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        if ((which ? ready_out : supply_enable) !== v) begin
            chk("wait", which ? ready_out : supply_enable, v);
            end_sim();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic session(input int m);
        int i;
        logic b;
        @(posedge clk);
        host_card_reset_in <= 1'b0;
        host_card_clock_in <= 1'b0;
        supply_request_mid_n <= (m != 0 && m != 4);
        supply_request_high_n <= (m == 0 || m == 4);
        wait_on(0, 1'b1, 4);
        chk("ready early", {ready_out, ready_oe_n}, 2'h0);
        chk("select first", supply_select, (m == 0 || m == 4) ? 2'h1 : 2'h2);
        if (m == 2 || m == 3) begin
            repeat (m == 2 ? 1 : 5) @(posedge clk);
            supply_request_mid_n <= 1'b0;
        end
        repeat (2) @(negedge clk);
        chk("select", supply_select, exp_sel[m]);
        chk("held low", {card_clock_out, card_reset_out}, 2'h0);
        wait_on(1, 1'b1, 12);
        repeat (2) @(negedge clk);
        chk("rx lines", {card_aux_line_a_in, card_aux_line_b_in, host_aux_line_b_oe_n, card_io_line_in}, 4'hf);
        for (i = 0; i < 6; i++) begin
            seed = xs(seed);
            b = seed[0];
            @(posedge clk);
            host_card_clock_in <= b;
            host_card_reset_in <= seed[1];
            repeat (2) @(negedge clk);
            chk("card clock", {card_clock_out, card_reset_out}, {b, seed[1]});
        end
        if (m == 0) begin
            for (i = 0; i < 2; i++) begin
                @(posedge clk);
                {host_pull, card_pull} <= i ? 2'h2 : 2'h1;
                repeat (3) @(negedge clk);
                chk("first fall", i ? {card_io_line_in, card_io_line_oe_n} : {host_io_line_in, host_io_line_oe_n}, 0);
                @(posedge clk);
                {host_pull, card_pull} <= 2'h0;
                repeat (3) @(negedge clk);
                chk("neutral", i ? card_io_line_in : host_io_line_in, 1);
            end
            @(posedge clk);
            chip_select <= 1'b0;
            @(posedge clk);
            supply_request_mid_n <= 1'b1;
            host_card_clock_in <= ~b;
            host_pull <= 1'b1;
            repeat (4) @(negedge clk);
            chk("latched", {supply_enable, card_clock_out}, {1'b1, b});
            chk("isolated", {card_io_line_in, host_pullup_strong}, 2'h2);
            chk("released", {card_status_n_oe_n, ready_oe_n, status_pullup_en}, 3'h6);
        end
        @(posedge clk);
        case (m)
            0: {chip_select, host_pull} <= 2'h2;
            1: {chip_select, card_overcurrent} <= 2'h1;
            2: power_down_ack <= 1'b1;
            3: card_presence_in <= 1'b0;
            default: sag <= 1'b1;
        endcase
        if (m == 1 || m >= 3) begin
            repeat (3) @(negedge clk);
            chk("fault flag", {card_status_n_out, card_status_n_oe_n}, {1'b0, m == 1});
        end
        wait_on(0, 1'b0, 16);
        chk("deactivated", {card_clock_out, card_reset_out, card_io_line_out, card_io_line_oe_n}, 0);
        @(posedge clk);
        supply_request_mid_n <= 1'b1;
        supply_request_high_n <= 1'b1;
        {card_overcurrent, power_down_ack, sag} <= 3'h0;
        card_presence_in <= 1'b1;
        chip_select <= 1'b1;
        repeat (4) @(negedge clk);
        chk("idle status", card_status_n_out, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk("card lines", {card_io_line_out, card_io_line_oe_n, card_aux_line_a_out, card_aux_line_b_out}, 0);
        chk("host lines", {host_io_line_oe_n, host_io_line_in, supply_enable}, 3'h6);
        @(posedge clk);
        card_presence_in <= 1'b0;
        card_overcurrent <= 1'b1;
        supply_request_mid_n <= 1'b0;
        repeat (3) @(negedge clk);
        chk("refused", {supply_enable, card_status_n_out}, 2'h0);
        @(posedge clk);
        supply_request_mid_n <= 1'b1;
        card_presence_in <= 1'b1;
        repeat (3) @(negedge clk);
        chk("presence", {card_status_n_out, supply_enable}, 2'h2);
        @(posedge clk);
        card_overcurrent <= 1'b0;
        for (m = 0; m < 5; m++)
            session(m);
        @(posedge clk);
        sag <= 1'b1;
        supply_request_mid_n <= 1'b0;
        wait_on(0, 1'b1, 4);
        repeat (30) @(negedge clk);
        chk("ready wait", supply_enable, 1);
        wait_on(0, 1'b0, 20);
        end_sim();
    end
endmodule
